// [thermal_sensor_pkg.sv]
// Constants and carrier types for the thermal sensor register block
package thermal_sensor_pkg;

	// Command codes seen on the link
	localparam logic [7:0] CMD_NONE = 8'h00;
	localparam logic [7:0] CMD_TEMP_READ = 8'h01;
	localparam logic [7:0] CMD_STATUS_READ = 8'h02;
	localparam logic [7:0] CMD_CONFIG_READ = 8'h03;
	localparam logic [7:0] CMD_RATE_READ = 8'h04;
	localparam logic [7:0] CMD_HIGH_LIMIT_READ = 8'h07;
	localparam logic [7:0] CMD_LOW_LIMIT_READ = 8'h08;
	localparam logic [7:0] CMD_CONFIG_WRITE = 8'h09;
	localparam logic [7:0] CMD_RATE_WRITE = 8'h0a;
	localparam logic [7:0] CMD_HIGH_LIMIT_WRITE = 8'h0d;
	localparam logic [7:0] CMD_LOW_LIMIT_WRITE = 8'h0e;
	localparam logic [7:0] CMD_SINGLE_CONVERSION = 8'h0f;

	// Status byte layout
	localparam int STAT_BUSY_BIT = 7;
	localparam int STAT_HIGH_BIT = 4;
	localparam int STAT_LOW_BIT = 3;
	localparam int STAT_OPEN_BIT = 2;

	// Configuration byte layout
	localparam int CFG_MASK_BIT = 7;
	localparam int CFG_STOP_BIT = 6;

	// Reset values
	localparam logic [7:0] TEMP_RESET = 8'h00;
	localparam logic [7:0] HIGH_LIMIT_RESET = 8'h7f;
	localparam logic [7:0] LOW_LIMIT_RESET = 8'hc9;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] RATE_RESET = 8'h02;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// Temperature encoding
	localparam logic signed [9:0] TEMP_SAT_MAX = 10'sh07f;
	localparam logic signed [9:0] TEMP_SAT_MIN = 10'sh000;

	// Conversion timing: slowest rate 0.0625 Hz is a 16000 ms period
	localparam logic [7:0] RATE_MAX_CODE = 8'h07;
	localparam longint unsigned SYS_CLK_KHZ = 64'd250000;
	localparam longint unsigned SLOW_PERIOD_MS = 64'd16000;
	localparam longint unsigned SLOW_PERIOD_CYCLES = SLOW_PERIOD_MS * SYS_CLK_KHZ;

	// Kinds of link transaction
	typedef enum logic [2:0] {
		TXN_WRITE_BYTE,
		TXN_READ_BYTE,
		TXN_SEND_BYTE,
		TXN_RECEIVE_BYTE,
		TXN_ALERT_RESPONSE
	} txn_kind_t;

	// One decoded transaction from the link
	typedef struct packed {
		txn_kind_t kind;
		logic [7:0] code;
		logic [7:0] data;
	} txn_t;

	// Answer to one transaction
	typedef struct packed {
		logic ack;
		logic [7:0] data;
	} rsp_t;

endpackage

// [smbus_thermal_sensor_regs.sv]
// Register, limit compare, conversion pacing and alert logic of the thermal sensor
`timescale 1ns/1ps

// What this block does
// - Each conversion result is stored as an 8-bit byte, sign bit zero.
// - Readings above 127 saturate to 127; readings at or below zero report zero.
// - Temperature and limit bytes use plain binary encoding.
// - High and low limits are held, each with own read and write command.
// - Reading at or above high limit sets high flag; at or below low sets low.
// - Status read clears alarm flags unless their condition still holds.
// - Status: busy bit 7, high bit 4, low bit 3, open bit 2.
// - Open-diode flag, reset zero, sets on a broken diode connection.
// - Config bit 7 masks alerting; cleared lets alert drive and answer.
// - While masked, an alert response read is not answered.
// - Setting the mask or reading status never releases a latched alert.
// - Config bit 6 set stops conversion at once; cleared runs automatically.
// - In stand-by a single conversion command still runs one conversion.
// - Config and rate each have separate read and write command codes.
// - Rate codes 0 to 7 give 0.0625 Hz doubling to 8 Hz.
// - Rate register resets to 02h, a quarter hertz.
// - Actual rate may stray thirty percent from nominal.
// - Unmasked alert output asserts on a limit crossing or open diode.
// - Latched alert releases only on alert response read, unless fault persists.
// - Single conversion command during a busy conversion is ignored.
// - Command codes decode to the registers and the single conversion start.
// - Alert response returns own 7-bit address in upper bits.
module smbus_thermal_sensor_regs #(
	parameter longint unsigned SLOW_PERIOD_CYCLES = thermal_sensor_pkg::SLOW_PERIOD_CYCLES
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic smbClk,
	input wire thermal_sensor_pkg::txn_t txnIn,
	input wire logic txnValid,
	output logic txnBusy,
	output thermal_sensor_pkg::rsp_t rspOut,
	output logic rspValid,
	input wire logic [6:0] ownAddr,
	output logic convStart,
	input wire logic convDone,
	input wire logic signed [9:0] rawTemp,
	input wire logic diodeOpen,
	input wire logic alertIn,
	output logic alertOutN,
	output logic alertOeN
);

	// ---------------- Link domain ----------------
	logic reqToggle_q;
	thermal_sensor_pkg::txn_t reqHold_q;
	logic ackSync1_q;
	logic ackSync2_q;
	logic ackSync3_q;
	logic ackStable_q;
	logic ackSeen_q;
	thermal_sensor_pkg::rsp_t rspOut_q;
	logic rspValid_q;
	logic ackToggle_q;
	thermal_sensor_pkg::rsp_t rspHold_q;
	wire logic txnTake;
	wire logic ackArrived;

	// One request in flight; the held copy stays put until the answer returns
	assign txnBusy = reqToggle_q != ackSeen_q;
	assign txnTake = txnValid && !txnBusy;
	assign ackArrived = ackStable_q != ackSeen_q;

	always_ff @(posedge smbClk or negedge nrst) begin
		if (!nrst) begin
			reqToggle_q <= 1'b0;
			reqHold_q <= '0;
		end else if (txnTake) begin
			reqToggle_q <= !reqToggle_q;
			reqHold_q <= txnIn;
		end
	end

	// Answer toggle sync; a change counts once stages two and three agree
	always_ff @(posedge smbClk or negedge nrst) begin
		if (!nrst) begin
			ackSync1_q <= 1'b0;
			ackSync2_q <= 1'b0;
			ackSync3_q <= 1'b0;
			ackStable_q <= 1'b0;
		end else begin
			ackSync1_q <= ackToggle_q;
			ackSync2_q <= ackSync1_q;
			ackSync3_q <= ackSync2_q;
			if (ackSync2_q == ackSync3_q) begin
				ackStable_q <= ackSync3_q;
			end
		end
	end

	// Answer data is stable in the core while the toggle is visible here
	always_ff @(posedge smbClk or negedge nrst) begin
		if (!nrst) begin
			ackSeen_q <= 1'b0;
			rspOut_q <= '0;
			rspValid_q <= 1'b0;
		end else begin
			rspValid_q <= ackArrived;
			if (ackArrived) begin
				ackSeen_q <= ackStable_q;
				rspOut_q <= rspHold_q;
			end
		end
	end

	assign rspOut = rspOut_q;
	assign rspValid = rspValid_q;

	// ---------------- Core domain: request crossing ----------------
	logic reqSync1_q;
	logic reqSync2_q;
	logic reqSync3_q;
	logic reqStable_q;
	logic reqSeen_q;
	wire logic reqArrived;

	// Held request is not sampled until the toggle has settled, so it is stable
	assign reqArrived = reqStable_q != reqSeen_q;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			reqSync1_q <= 1'b0;
			reqSync2_q <= 1'b0;
			reqSync3_q <= 1'b0;
			reqStable_q <= 1'b0;
			reqSeen_q <= 1'b0;
		end else begin
			reqSync1_q <= reqToggle_q;
			reqSync2_q <= reqSync1_q;
			reqSync3_q <= reqSync2_q;
			if (reqSync2_q == reqSync3_q) begin
				reqStable_q <= reqSync3_q;
			end
			reqSeen_q <= reqStable_q;
		end
	end

	// ---------------- Core domain: decode ----------------
	logic [7:0] temp_q;
	logic [7:0] highLimit_q;
	logic [7:0] lowLimit_q;
	logic [7:0] rate_q;
	logic cfgMask_q;
	logic cfgStop_q;
	logic highFlag_q;
	logic lowFlag_q;
	logic openFlag_q;
	logic busy_q;
	logic alertLatch_q;
	logic [7:0] readPtr_q;
	logic diodeSync1_q;
	logic diodeSync2_q;
	logic diodeSync3_q;
	logic diodeOpen_q;

	wire thermal_sensor_pkg::txn_t req;
	wire logic isWrite;
	wire logic isRead;
	wire logic isSend;
	wire logic isRecv;
	wire logic isAra;
	wire logic [7:0] selCode;
	wire logic wrHigh;
	wire logic wrLow;
	wire logic wrConfig;
	wire logic wrRate;
	wire logic singleCmd;
	wire logic statusRead;
	wire logic araRead;
	wire logic araAnswer;

	assign req = reqHold_q;
	assign isWrite = reqArrived && req.kind == thermal_sensor_pkg::TXN_WRITE_BYTE;
	assign isRead = reqArrived && req.kind == thermal_sensor_pkg::TXN_READ_BYTE;
	assign isSend = reqArrived && req.kind == thermal_sensor_pkg::TXN_SEND_BYTE;
	assign isRecv = reqArrived && req.kind == thermal_sensor_pkg::TXN_RECEIVE_BYTE;
	assign isAra = reqArrived && req.kind == thermal_sensor_pkg::TXN_ALERT_RESPONSE;

	// Read byte uses its own code; receive byte reuses the last pointer
	assign selCode = isRead ? req.code : readPtr_q;

	// Write commands; writes aimed at read codes change nothing
	assign wrHigh = isWrite && req.code == thermal_sensor_pkg::CMD_HIGH_LIMIT_WRITE;
	assign wrLow = isWrite && req.code == thermal_sensor_pkg::CMD_LOW_LIMIT_WRITE;
	assign wrConfig = isWrite && req.code == thermal_sensor_pkg::CMD_CONFIG_WRITE;
	assign wrRate = isWrite && req.code == thermal_sensor_pkg::CMD_RATE_WRITE;
	assign singleCmd = (isSend || isWrite) && req.code == thermal_sensor_pkg::CMD_SINGLE_CONVERSION;
	assign statusRead = (isRead || isRecv) && selCode == thermal_sensor_pkg::CMD_STATUS_READ;

	// Masked or quiet sensors leave the alert response to others
	assign araRead = isAra;
	assign araAnswer = araRead && alertLatch_q && !cfgMask_q;

	// Status byte; unnamed bits read zero
	wire logic [7:0] statusByte;
	assign statusByte = (8'(busy_q) << thermal_sensor_pkg::STAT_BUSY_BIT)
		| (8'(highFlag_q) << thermal_sensor_pkg::STAT_HIGH_BIT)
		| (8'(lowFlag_q) << thermal_sensor_pkg::STAT_LOW_BIT)
		| (8'(openFlag_q) << thermal_sensor_pkg::STAT_OPEN_BIT);

	wire logic [7:0] configByte;
	assign configByte = (8'(cfgMask_q) << thermal_sensor_pkg::CFG_MASK_BIT)
		| (8'(cfgStop_q) << thermal_sensor_pkg::CFG_STOP_BIT);

	// Read mux; reserved and write codes return zero
	wire logic [7:0] readByte;
	assign readByte = (selCode == thermal_sensor_pkg::CMD_TEMP_READ) ? temp_q
		: (selCode == thermal_sensor_pkg::CMD_STATUS_READ) ? statusByte
		: (selCode == thermal_sensor_pkg::CMD_CONFIG_READ) ? configByte
		: (selCode == thermal_sensor_pkg::CMD_RATE_READ) ? rate_q
		: (selCode == thermal_sensor_pkg::CMD_HIGH_LIMIT_READ) ? highLimit_q
		: (selCode == thermal_sensor_pkg::CMD_LOW_LIMIT_READ) ? lowLimit_q
		: thermal_sensor_pkg::BYTE_ZERO;

	// Answer to the current request; alert response carries address over a zero
	wire thermal_sensor_pkg::rsp_t rspNext;
	assign rspNext.ack = isAra ? araAnswer : 1'b1;
	assign rspNext.data = isAra ? {ownAddr, 1'b0} : readByte;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ackToggle_q <= 1'b0;
			rspHold_q <= '0;
		end else if (reqArrived) begin
			ackToggle_q <= !ackToggle_q;
			rspHold_q <= rspNext;
		end
	end

	// Pointer for receive byte; starts at the reserved code, so reads return zero
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			readPtr_q <= thermal_sensor_pkg::CMD_NONE;
		end else if (isRead || (isSend && !singleCmd)) begin
			readPtr_q <= req.code;
		end
	end

	// Writable registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			highLimit_q <= thermal_sensor_pkg::HIGH_LIMIT_RESET;
			lowLimit_q <= thermal_sensor_pkg::LOW_LIMIT_RESET;
			rate_q <= thermal_sensor_pkg::RATE_RESET;
			cfgMask_q <= thermal_sensor_pkg::CONFIG_RESET[thermal_sensor_pkg::CFG_MASK_BIT];
			cfgStop_q <= thermal_sensor_pkg::CONFIG_RESET[thermal_sensor_pkg::CFG_STOP_BIT];
		end else begin
			if (wrHigh) begin
				highLimit_q <= req.data;
			end
			if (wrLow) begin
				lowLimit_q <= req.data;
			end
			if (wrRate) begin
				rate_q <= req.data;
			end
			if (wrConfig) begin
				cfgMask_q <= req.data[thermal_sensor_pkg::CFG_MASK_BIT];
				cfgStop_q <= req.data[thermal_sensor_pkg::CFG_STOP_BIT];
			end
		end
	end

	// ---------------- Conversion pacing ----------------
	// Reserved rate codes run at the fastest rate rather than stall the sensor
	wire logic [2:0] rateSel;
	wire logic [31:0] period;
	logic [31:0] rateCnt_q;
	wire logic autoTick;
	wire logic oneShotStart;
	wire logic startNow;
	wire logic abortNow;

	assign rateSel = (rate_q > thermal_sensor_pkg::RATE_MAX_CODE) ? 3'(thermal_sensor_pkg::RATE_MAX_CODE) : rate_q[2:0];
	assign period = 32'(SLOW_PERIOD_CYCLES >> rateSel);
	assign autoTick = !cfgStop_q && rateCnt_q >= period - 32'd1;
	assign oneShotStart = singleCmd && cfgStop_q && !busy_q;
	assign startNow = (autoTick && !busy_q) || oneShotStart;
	assign abortNow = busy_q && (wrConfig && req.data[thermal_sensor_pkg::CFG_STOP_BIT]);

	// Counter idles in stand-by so each return to auto waits a full period
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rateCnt_q <= 32'h0000_0000;
		end else if (cfgStop_q || autoTick) begin
			rateCnt_q <= 32'h0000_0000;
		end else begin
			rateCnt_q <= rateCnt_q + 32'd1;
		end
	end

	// Busy spans start to result store; a stop drops it and discards the result
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			busy_q <= 1'b0;
			convStart <= 1'b0;
		end else begin
			convStart <= startNow && !abortNow;
			if (startNow && !abortNow) begin
				busy_q <= 1'b1;
			end else if (abortNow || convDone) begin
				busy_q <= 1'b0;
			end
		end
	end

	// ---------------- Result, compare and flags ----------------
	wire logic [7:0] satTemp;
	wire logic resultStore;
	wire logic highNow;
	wire logic lowNow;
	wire logic highCond;
	wire logic lowCond;

	// Clamp to 0..127 so the sign bit always reads zero
	assign satTemp = (rawTemp > thermal_sensor_pkg::TEMP_SAT_MAX) ? thermal_sensor_pkg::TEMP_SAT_MAX[7:0]
		: (rawTemp <= thermal_sensor_pkg::TEMP_SAT_MIN) ? thermal_sensor_pkg::TEMP_SAT_MIN[7:0]
		: rawTemp[7:0];
	assign resultStore = convDone && busy_q && !abortNow;

	// Compare the fresh result, or the stored one between conversions
	assign highNow = resultStore ? (satTemp >= highLimit_q) : 1'b0;
	assign lowNow = resultStore ? (satTemp <= lowLimit_q) : 1'b0;
	assign highCond = temp_q >= highLimit_q;
	assign lowCond = temp_q <= lowLimit_q;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			temp_q <= thermal_sensor_pkg::TEMP_RESET;
		end else if (resultStore) begin
			temp_q <= satTemp;
		end
	end

	// Diode open level comes from the analog side, so synchronise it
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			diodeSync1_q <= 1'b0;
			diodeSync2_q <= 1'b0;
			diodeSync3_q <= 1'b0;
			diodeOpen_q <= 1'b0;
		end else begin
			diodeSync1_q <= diodeOpen;
			diodeSync2_q <= diodeSync1_q;
			diodeSync3_q <= diodeSync2_q;
			if (diodeSync2_q == diodeSync3_q) begin
				diodeOpen_q <= diodeSync3_q;
			end
		end
	end

	// Sticky flags; a set or a standing condition wins over the read clear
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			highFlag_q <= 1'b0;
			lowFlag_q <= 1'b0;
			openFlag_q <= 1'b0;
		end else begin
			highFlag_q <= highNow || (statusRead ? (highFlag_q && highCond) : highFlag_q);
			lowFlag_q <= lowNow || (statusRead ? (lowFlag_q && lowCond) : lowFlag_q);
			openFlag_q <= diodeOpen_q || (statusRead ? 1'b0 : openFlag_q);
		end
	end

	// ---------------- Alert ----------------
	wire logic faultEvent;
	wire logic faultPersists;

	assign faultEvent = highNow || lowNow || diodeOpen_q;
	assign faultPersists = highCond || lowCond || diodeOpen_q;

	// Only the answered alert response releases; mask and status reads do not
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			alertLatch_q <= 1'b0;
		end else if (faultEvent && !cfgMask_q) begin
			alertLatch_q <= 1'b1;
		end else if (araAnswer && !faultPersists) begin
			alertLatch_q <= 1'b0;
		end
	end

	// Open-drain pin: the level is always low, the enable does the driving
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			alertOutN <= 1'b0;
			alertOeN <= 1'b1;
		end else begin
			alertOutN <= 1'b0;
			alertOeN <= !alertLatch_q;
		end
	end

endmodule

// [sensor_sva.sv]
// Port assertions for the thermal sensor block
`timescale 1ns/1ps
module sensor_sva (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic smbClk,
	input wire logic txnValid,
	input wire logic txnBusy,
	input wire logic rspValid,
	input wire logic convStart,
	input wire logic alertOutN,
	input wire logic alertOeN
);
	// Link side: one request at a time, each answered in bounded time
	property p_take;
		@(posedge smbClk) disable iff (!nrst) txnValid && !txnBusy |=> txnBusy ##[1:9] rspValid;
	endproperty
	a_take: assert property (p_take) else $error("request not answered in time");
	property p_busy;
		@(posedge smbClk) disable iff (!nrst) txnBusy |=> txnBusy || rspValid;
	endproperty
	a_busy: assert property (p_busy) else $error("busy dropped without an answer");
	property p_idle;
		@(posedge smbClk) disable iff (!nrst) !txnBusy && !txnValid |=> !txnBusy && !rspValid;
	endproperty
	a_idle: assert property (p_idle) else $error("link active without a request");
	property p_pulse;
		@(posedge smbClk) disable iff (!nrst) rspValid |=> !rspValid;
	endproperty
	a_pulse: assert property (p_pulse) else $error("answer strobe too long");
	property p_done;
		@(posedge smbClk) disable iff (!nrst) rspValid |-> !txnBusy && $past(txnBusy);
	endproperty
	a_done: assert property (p_done) else $error("answer without a pending request");
	// Converter side: no new start in the two cycles after a start
	property p_gap;
		@(posedge sys_clk) disable iff (!nrst) convStart |=> !convStart [*2];
	endproperty
	a_gap: assert property (p_gap) else $error("start during a running conversion");
	// Open-drain pin: only the enable moves, and idle link never releases it
	property p_pin;
		@(posedge sys_clk) disable iff (!nrst) !alertOutN;
	endproperty
	a_pin: assert property (p_pin) else $error("alert pin driven high");
	property p_hold;
		@(posedge sys_clk) disable iff (!nrst) !alertOeN && !txnBusy |=> !alertOeN;
	endproperty
	a_hold: assert property (p_hold) else $error("alert released without a transfer");
endmodule

// [host_model.sv]
// Host controller model: gated link clock and one-byte transfers
`timescale 1ns/1ps
module host_model (
	input wire logic nrst,
	output logic smbClk,
	output thermal_sensor_pkg::txn_t txnIn,
	output logic txnValid,
	input wire thermal_sensor_pkg::rsp_t rspOut,
	input wire logic rspValid
);
	logic run = 1'h0;
	int idle = 0;
	// Host view of a byte: sign set and not all ones means zero degrees
	wire [7:0] rspDeg = (rspOut.data[7] && rspOut.data != 8'hff) ? 8'h00 : rspOut.data;
	// Clock runs in reset and frames only, stands low between them; skew keeps its edges off core edges
	initial begin
		smbClk = 1'h0;
		txnIn = '0;
		txnValid = 1'h0;
		#0.3;
		forever begin
			#62.5;
			if (run || !nrst || smbClk) smbClk = ~smbClk;
		end
	end
	// One transfer; idle cycles make a slow host, bus is scrambled once released
	task automatic xfer(input thermal_sensor_pkg::txn_kind_t kind, input logic [7:0] code,
		input logic [7:0] data, output thermal_sensor_pkg::rsp_t rsp, output logic got);
		run = 1'h1;
		repeat (idle + 1) @(negedge smbClk);
		txnIn = '{kind, code, data};
		txnValid = 1'h1;
		@(negedge smbClk);
		txnValid = 1'h0;
		txnIn = ~txnIn;
		got = 1'h0;
		for (int n = 0; n < 12 && !got; n++) begin
			@(negedge smbClk);
			got = rspValid;
			rsp = rspOut;
		end
		repeat (2) @(negedge smbClk);
		run = 1'h0;
	endtask
endmodule

// [tb_top.sv]
// Testbench for the thermal sensor block: scenarios, converter stand-in, verdict
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 1'h0;
	logic nrst = 1'h0;
	logic smbClk, txnValid, txnBusy, rspValid, convStart, alertOutN, alertOeN;
	logic convDone = 1'h0;
	logic diodeOpen = 1'h0;
	logic signed [9:0] rawTemp = 10'sh000;
	thermal_sensor_pkg::txn_t txnIn;
	thermal_sensor_pkg::rsp_t rspOut, r;
	wire alertIn = alertOeN ? 1'h1 : alertOutN;
	int errors = 0;
	int num_checks = 0;
	int starts = 0;
	int pend = 0;
	int lat = 4;
	logic signed [9:0] tv[5] = '{10'sh0c8, 10'sh07f, 10'sh064, 10'sh000, -10'sh005};
	logic [7:0] te[5] = '{8'h7f, 8'h7f, 8'h64, 8'h00, 8'h00};

	always #2 sys_clk = ~sys_clk;

	smbus_thermal_sensor_regs #(.SLOW_PERIOD_CYCLES(64'h10000)) i_dut (.sys_clk(sys_clk), .nrst(nrst),
		.smbClk(smbClk), .txnIn(txnIn), .txnValid(txnValid), .txnBusy(txnBusy), .rspOut(rspOut),
		.rspValid(rspValid), .ownAddr(7'h2b), .convStart(convStart), .convDone(convDone), .rawTemp(rawTemp),
		.diodeOpen(diodeOpen), .alertIn(alertIn), .alertOutN(alertOutN), .alertOeN(alertOeN));
	host_model i_host (.nrst(nrst), .smbClk(smbClk), .txnIn(txnIn), .txnValid(txnValid), .rspOut(rspOut),
		.rspValid(rspValid));

	// Converter stand-in: answers each start after lat cycles
	always @(negedge sys_clk) begin
		convDone <= 1'h0;
		if (convStart) begin
			starts <= starts + 1;
			pend <= lat;
		end else if (pend > 1) pend <= pend - 1;
		else if (pend == 1) begin
			pend <= 0;
			convDone <= 1'h1;
		end
	end

	task automatic test_done();
		$display("checks %0d, mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] want);
		num_checks++;
		if (seen !== want) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, want, seen);
		end
	endtask
	// Bus helpers; a transfer without answer ends the run
	task automatic go(input thermal_sensor_pkg::txn_kind_t k, input logic [7:0] c, input logic [7:0] d);
		logic got;
		i_host.xfer(k, c, d, r, got);
		if (got !== 1'h1) begin
			errors++;
			test_done();
		end
	endtask
	task automatic rdc(input logic [7:0] c, input logic [7:0] want, input logic [7:0] m = 8'hff);
		go(thermal_sensor_pkg::TXN_READ_BYTE, c, 8'h00);
		chk($sformatf("code %h", c), r.data & m, want);
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		go(thermal_sensor_pkg::TXN_WRITE_BYTE, c, d);
		chk("write ack", {7'h00, r.ack}, 8'h01);
	endtask
	task automatic ara(input logic [7:0] want);
		go(thermal_sensor_pkg::TXN_ALERT_RESPONSE, 8'h00, 8'h00);
		chk("alert reply", r.ack ? r.data : 8'h00, want);
	endtask
	task automatic pin(input logic e);
		chk("alert enable", {7'h00, alertOeN}, {7'h00, e});
	endtask
	task automatic conv(input logic signed [9:0] t);
		int s;
		s = starts;
		rawTemp = t;
		go(thermal_sensor_pkg::TXN_SEND_BYTE, 8'h0f, 8'h00);
		settle(s);
		chk("single start", 8'(starts - s), 8'h01);
	endtask
	// Waits for a start beyond count s and its answer; a stall ends the run
	task automatic settle(input int s);
		int n;
		n = 0;
		while ((starts == s || pend != 0) && n < 3000) begin
			@(negedge sys_clk);
			n++;
		end
		if (n == 3000) begin
			errors++;
			test_done();
		end
		repeat (4) @(negedge sys_clk);
	endtask
	task automatic wait_start(output int n);
		n = 0;
		while (convStart !== 1'h1 && n < 2000) begin
			@(negedge sys_clk);
			n++;
		end
		if (n == 2000) begin
			errors++;
			test_done();
		end
	endtask

	// Reset values, read pointer, then masked stand-by
	task automatic t_reset();
		pin(1'h1);
		rdc(8'h01, 8'h00);
		rdc(8'h02, 8'h00);
		rdc(8'h02, 8'h00);
		rdc(8'h03, 8'h00);
		rdc(8'h04, 8'h02);
		rdc(8'h07, 8'h7f);
		rdc(8'h08, 8'hc9);
		go(thermal_sensor_pkg::TXN_RECEIVE_BYTE, 8'h00, 8'h00);
		chk("repeat read", r.data, 8'hc9);
		wr(8'h09, 8'hff);
	endtask
	// Slow host: limits, reserved rate, writes to read-only and reserved codes
	task automatic t_regs();
		i_host.idle = 3;
		wr(8'h0d, 8'h50);
		wr(8'h0e, 8'h10);
		wr(8'h0a, 8'h08);
		wr(8'h01, 8'hff);
		wr(8'h05, 8'hff);
		rdc(8'h07, 8'h50);
		rdc(8'h08, 8'h10);
		rdc(8'h04, 8'h08);
		rdc(8'h01, 8'h00);
		rdc(8'h03, 8'hc0);
		go(thermal_sensor_pkg::TXN_SEND_BYTE, 8'h07, 8'h00);
		go(thermal_sensor_pkg::TXN_RECEIVE_BYTE, 8'h00, 8'h00);
		chk("pointer after send", r.data, 8'h50);
		i_host.idle = 0;
	endtask
	// Busy flag, refused second start, saturation table, sticky flags under mask
	task automatic t_conv();
		rawTemp = 10'sh030;
		lat = 2000;
		go(thermal_sensor_pkg::TXN_SEND_BYTE, 8'h0f, 8'h00);
		rdc(8'h02, 8'h80, 8'h80);
		go(thermal_sensor_pkg::TXN_SEND_BYTE, 8'h0f, 8'h00);
		settle(0);
		chk("starts", 8'(starts), 8'h01);
		lat = 4;
		rdc(8'h01, 8'h30);
		foreach (tv[i]) begin
			conv(tv[i]);
			rdc(8'h01, te[i]);
			chk("host degrees", i_host.rspDeg, te[i]);
		end
		conv(10'sh030);
		rdc(8'h02, 8'h18);
		rdc(8'h02, 8'h00);
		pin(1'h1);
	endtask
	// Alarm latching, mask, status reads and alert response release
	task automatic t_alarm();
		wr(8'h09, 8'h40);
		conv(10'sh060);
		rdc(8'h02, 8'h10);
		pin(1'h0);
		conv(10'sh030);
		rdc(8'h02, 8'h10);
		rdc(8'h02, 8'h00);
		wr(8'h09, 8'hc0);
		pin(1'h0);
		ara(8'h00);
		wr(8'h09, 8'h40);
		ara(8'h56);
		pin(1'h1);
		conv(10'sh010);
		rdc(8'h02, 8'h08);
		ara(8'h56);
		pin(1'h0);
		conv(10'sh030);
		ara(8'h56);
		pin(1'h1);
	endtask
	// Broken diode connection
	task automatic t_open();
		go(thermal_sensor_pkg::TXN_READ_BYTE, 8'h02, 8'h00);
		diodeOpen = 1'h1;
		repeat (8) @(negedge sys_clk);
		rdc(8'h02, 8'h04);
		pin(1'h0);
		ara(8'h56);
		pin(1'h0);
		diodeOpen = 1'h0;
		repeat (8) @(negedge sys_clk);
		go(thermal_sensor_pkg::TXN_READ_BYTE, 8'h02, 8'h00);
		rdc(8'h02, 8'h00);
		ara(8'h56);
		pin(1'h1);
	endtask
	// Auto pacing at the fastest rate, then an immediate stop
	task automatic t_auto();
		int a;
		int b;
		wr(8'h0a, 8'h07);
		wr(8'h09, 8'h00);
		wait_start(a);
		@(negedge sys_clk);
		wait_start(b);
		chk("auto period", {7'h00, b >= 358 && b <= 666}, 8'h01);
		wr(8'h09, 8'h40);
		a = starts;
		repeat (1500) @(negedge sys_clk);
		chk("stand-by starts", 8'(starts - a), 8'h00);
	endtask

	// Reset spans link clock edges too, then the scenarios in order
	initial begin
		repeat (3) @(negedge smbClk);
		@(negedge sys_clk);
		nrst = 1'h1;
		t_reset();
		t_regs();
		t_conv();
		t_alarm();
		t_open();
		t_auto();
		test_done();
	end
endmodule

bind smbus_thermal_sensor_regs sensor_sva i_sva (.sys_clk(sys_clk), .nrst(nrst), .smbClk(smbClk),
	.txnValid(txnValid), .txnBusy(txnBusy), .rspValid(rspValid), .convStart(convStart), .alertOutN(alertOutN),
	.alertOeN(alertOeN));
